// file: bench/asc_ctrl_monitor.sv
// Pin timing checks for the static memory controller
`timescale 1ns/100ps
module asc_ctrl_monitor #(
   parameter int AW = 20,
   parameter int DW = 16
) (
   input wire logic mclk, // Clock
   input wire logic rst_n, // Reset, low
   input wire logic req_valid, // Request present
   input wire logic req_ready, // Request taken
   input wire logic req_write, // Write request
   input wire logic rsp_valid, // Read data pulse
   input wire logic [AW-1:0] mem_addr, // Address pins
   input wire logic chip_select_n, // Low select
   input wire logic chip_select_p, // High select
   input wire logic gate_n, // Output gate
   input wire logic write_strobe_n, // Write strobe
   input wire logic upper_lane_enable_n, // Upper lane
   input wire logic lower_lane_enable_n, // Lower lane
   input wire logic [DW-1:0] mem_dq_o, // Bus drive value
   input wire logic [DW-1:0] mem_dq_oe // Bus drive enable
);
   wire sel = !chip_select_n && chip_select_p;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   take_spacing_a: assert property (
      req_valid && req_ready |=> !req_ready [*5]) else $error("request taken too soon");
   read_answer_a: assert property (
      req_valid && req_ready && !req_write |-> ##9 rsp_valid) else $error("read answer late");
   strobe_pulse_a: assert property (
      $fell(write_strobe_n) |-> !write_strobe_n [*5]) else $error("strobe pulse short");
   select_hold_a: assert property (
      $rose(write_strobe_n) |-> $past(sel, 5) && $past(sel, 1)) else $error("select too short");
   addr_stable_a: assert property (
      !write_strobe_n && !$past(write_strobe_n) |-> $stable(mem_addr))
      else $error("address moved in write");
   wdata_setup_a: assert property (
      $rose(write_strobe_n) |-> $past(mem_dq_oe, 4) != 0 && $past(mem_dq_oe, 4) ==
      $past(mem_dq_oe, 1) && $past(mem_dq_o, 4) == $past(mem_dq_o, 1))
      else $error("write data setup short");
   write_overlap_a: assert property (
      !write_strobe_n |-> sel && !(upper_lane_enable_n && lower_lane_enable_n))
      else $error("strobe without select");
   bus_turn_a: assert property (
      mem_dq_oe != 0 |-> gate_n && $past(gate_n, 3)) else $error("bus driven during read");
endmodule

bind asc_ctrl asc_ctrl_monitor #(.AW(AW), .DW(DW)) i_mon (.mclk(mclk), .rst_n(rst_n),
   .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
   .rsp_valid(rsp_valid), .mem_addr(mem_addr), .chip_select_n(chip_select_n),
   .chip_select_p(chip_select_p), .gate_n(gate_n), .write_strobe_n(write_strobe_n),
   .upper_lane_enable_n(upper_lane_enable_n), .lower_lane_enable_n(lower_lane_enable_n),
   .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));

// file: bench/asc_sram_model.sv
// Behavioural asynchronous 16-bit static memory with byte lanes
`timescale 1ns/100ps
module asc_sram_model #(
   parameter int DLY = 10,
   parameter int PD_DLY = 45
) (
   input wire logic [19:0] addr, // Address
   input wire logic cs_n, // Low select
   input wire logic cs_p, // High select
   input wire logic oe_n, // Output gate
   input wire logic we_n, // Write strobe
   input wire logic ub_n, // Upper lane
   input wire logic lb_n, // Lower lane
   input wire logic [15:0] d, // Bus level
   output logic [15:0] q, // Read value
   output logic [15:0] en // Drive enable per bit
);
   logic [15:0] mem [0:15];
   wire sel = !cs_n && cs_p;
   // Powered at once on select, standby only after the longest allowed delay
   wire #(0, PD_DLY) powered = sel;
   wire [15:0] lanes = {{8{!ub_n}}, {8{!lb_n}}};
   // Small array; only low address bits decode
   always @(posedge we_n) begin
      if (sel) mem[addr[3:0]] = (mem[addr[3:0]] & ~lanes) | (d & lanes);
   end
   // One delay keeps both drive-start minimum and release maximum
   assign #DLY en = (sel && powered && !oe_n && we_n) ?
      lanes : 16'h0000;
   assign #DLY q = mem[addr[3:0]];
endmodule

// file: bench/testbench.sv
// Self-checking bench for the static memory controller
`timescale 1ns/100ps
module testbench;
   import asc_pkg::*;
   logic mclk, rst_n, req_valid, req_ready, req_write, rsp_valid;
   logic cs_n, cs_p, g_n, we_n, ub_n, lb_n;
   logic [19:0] req_addr, mem_addr;
   logic [15:0] req_wdata, rsp_rdata, dq_o, dq_oe, dq_i, mq, men;
   asc_lanes_t req_lanes;
   int num_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   // Bus bits driven by neither side show the inverse of the model value
   assign dq_i = (dq_oe & dq_o) | (~dq_oe & men & mq) | (~dq_oe & ~men & ~mq);
   asc_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .chip_select_n(cs_n),
      .chip_select_p(cs_p), .gate_n(g_n), .write_strobe_n(we_n), .upper_lane_enable_n(ub_n),
      .lower_lane_enable_n(lb_n), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_dq_i(dq_i));
   asc_sram_model i_mem (.addr(mem_addr), .cs_n(cs_n), .cs_p(cs_p), .oe_n(g_n), .we_n(we_n),
      .ub_n(ub_n), .lb_n(lb_n), .d(dq_i), .q(mq), .en(men));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic end_of_test;
      if (num_errors == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (!ok) begin
         num_errors++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic take(input logic w, input logic [19:0] a, input logic [15:0] d,
      input asc_lanes_t l);
      int n;
      n = 0;
      @(posedge mclk);
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      req_lanes <= l;
      req_valid <= 1'b1;
      do @(posedge mclk); while (req_ready !== 1'b1 && ++n < 40);
      req_valid <= 1'b0;
      chk(n < 40, "request never taken");
   endtask
   task automatic rd(input logic [19:0] a, input logic [15:0] exp);
      take(1'b0, a, 16'h0000, 2'b11);
      #1;
      chk(mem_addr === a, "address pins wrong");
      repeat (8) @(posedge mclk);
      #1;
      chk(rsp_valid === 1'b1 && rsp_rdata === exp, "read data wrong");
   endtask
   task automatic t_far_addrs;
      take(1'b1, 20'h00001, 16'h1234, 2'b11);
      take(1'b1, 20'hFFFFE, 16'hFEDC, 2'b11);
      rd(20'h00001, 16'h1234);
      rd(20'hFFFFE, 16'hFEDC);
   endtask
   task automatic t_lanes;
      take(1'b1, 20'h00005, 16'hA5C3, 2'b11);
      take(1'b1, 20'h00005, 16'h1E77, 2'b01);
      rd(20'h00005, 16'hA577);
      take(1'b1, 20'h00005, 16'h9900, 2'b10);
      rd(20'h00005, 16'h9977);
   endtask
   task automatic t_reset_read;
      take(1'b0, 20'h00001, 16'h0000, 2'b11);
      repeat (4) @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      chk(cs_n === 1'b1 && g_n === 1'b1 && we_n === 1'b1 && dq_oe === 16'h0000,
         "pins busy");
      chk(rsp_valid === 1'b0, "aborted read answered");
      rd(20'h00005, 16'h9977);
   endtask
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 20'h00000;
      req_wdata = 16'h0000;
      req_lanes = 2'b00;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      t_far_addrs();
      t_lanes();
      t_reset_read();
      end_of_test();
   end
endmodule

// file: design/asc_ctrl.sv
// Host-side controller driving an asynchronous 16-bit static memory
//
// Functional notes
// [RULE1] Read cycles spaced 45 ns; data 45 ns after address
// [RULE2] Memory holds old data 10 ns after address
// [RULE3] Data valid 45 ns after both selects active
// [RULE4] Data valid 22 ns after gate falls
// [RULE5] Outputs drive no sooner than 5 ns
// [RULE6] Outputs release 18 ns after gate rises
// [RULE7] Outputs drive no sooner than 10 ns after select
// [RULE8] Outputs release 18 ns after deselect
// [RULE9] Active power immediately on select
// [RULE10] Standby up to 45 ns after deselect
// [RULE11] Lane data valid 45 ns after enable
// [RULE12] Lane drive 10 ns min, release 18 max
// [RULE13] Write cycle lasts at least 45 ns
// [RULE14] Selects active 35 ns before write end
// [RULE15] Address stable 35 ns before write end
// [RULE16] Address may change right at write end
// [RULE17] Write strobe low at least 35 ns
// [RULE18] Byte enables low 35 ns before end
// [RULE19] Write data valid 25 ns before end
// [RULE20] Memory releases bus 18 ns after strobe
// [RULE21] Memory drives no sooner 10 ns after strobe
// [RULE22] Write is overlap of strobe, selects, enables
// [RULE23] Deselected memory outputs are high impedance
// [RULE24] Controller never drives while memory drives
// [RULE25] Times rounded up to whole clock cycles
// [RULE26] Lower enable bits 7:0, upper bits 15:8
`timescale 1ns/100ps
`include "asc_map.svh"
module asc_ctrl #(
   parameter int AW = 20, // Memory address width
   parameter int DW = 16 // Data width, two byte lanes
) (
   input wire logic mclk, // 125 MHz clock
   input wire logic rst_n, // Synchronous reset, low
   input wire logic req_valid, // Request present
   output logic req_ready, // Request taken this cycle
   input wire logic req_write, // 1 write, 0 read
   input wire logic [AW-1:0] req_addr, // Word address
   input wire logic [DW-1:0] req_wdata, // Write data
   input wire asc_pkg::asc_lanes_t req_lanes, // Lane select, bit0 low byte
   output logic rsp_valid, // Read data pulse
   output logic [DW-1:0] rsp_rdata, // Read data
   output logic [AW-1:0] mem_addr, // Address pins
   output logic chip_select_n, // Low-active select
   output logic chip_select_p, // High-active select
   output logic gate_n, // Output gate, low reads
   output logic write_strobe_n, // Write strobe
   output logic upper_lane_enable_n, // Bits 15:8 enable
   output logic lower_lane_enable_n, // Bits 7:0 enable
   output logic [DW-1:0] mem_dq_o, // Data bus drive value
   output logic [DW-1:0] mem_dq_oe, // Data bus drive enable, high drives
   input wire logic [DW-1:0] mem_dq_i // Data bus level
);
   import asc_pkg::*;

   // Each time rounded up to whole cycles [RULE25]
   localparam int RD_CYC = `ASC_CYC_UP(`ASC_ADDR_ACCESS_MAX_NS) + `ASC_SYNC_STAGES; // Sync flops
   localparam int RC_CYC = `ASC_CYC_UP(`ASC_READ_CYCLE_MIN_NS);
   localparam int TURN_CYC = `ASC_CYC_UP(`ASC_GATE_RELEASE_MAX_NS);
   localparam int REL_CYC = `ASC_CYC_UP(`ASC_STROBE_RELEASE_MAX_NS);
   localparam int PWE_CYC = `ASC_CYC_UP(`ASC_STROBE_PULSE_MIN_NS);
   localparam int WC_CYC = `ASC_CYC_UP(`ASC_WRITE_CYCLE_MIN_NS);
   localparam int TW = 4;

   // Refused at elaboration: lanes are fixed and the read access and write cycle counts must fit the timer
   if (DW != 2 * `ASC_LANE_W) begin : g_dw_check
      $error("asc_ctrl serves two 8-bit lanes only");
   end
   if (AW < 1) begin : g_aw_check
      $error("asc_ctrl needs an address");
   end
   if (RD_CYC >= (1 << TW) || WC_CYC > (1 << TW)) begin : g_tw_check
      $error("asc_ctrl timer too narrow");
   end

   asc_timer_if #(.W(TW)) tif ();
   asc_timer #(.W(TW)) u_tmr (.mclk(mclk), .rst_n(rst_n), .tif(tif));

   asc_state_t st_r, st_nxt;
   logic [AW-1:0] addr_r, addr_nxt;
   logic [DW-1:0] wdata_r, wdata_nxt;
   asc_lanes_t lanes_r, lanes_nxt;
   logic sel_r, sel_nxt;
   logic gate_r, gate_nxt;
   logic we_r, we_nxt;
   logic drive_r, drive_nxt;
   logic rsp_r, rsp_nxt;
   logic [DW-1:0] rdata_r, rdata_nxt;
   logic [DW-1:0] dq_s1_r, dq_s2_r;
   logic [TW-1:0] wait_r, wait_nxt;

   // Bus pins are outside the clock domain: two flops before use
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dq_s1_r <= '0;
         dq_s2_r <= '0;
      end else begin
         dq_s1_r <= mem_dq_i;
         dq_s2_r <= dq_s1_r;
      end
   end

   assign req_ready = (st_r == ASC_IDLE) && tif.done && (wait_r == '0);

   always_comb begin
      st_nxt = st_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      lanes_nxt = lanes_r;
      sel_nxt = sel_r;
      gate_nxt = gate_r;
      we_nxt = we_r;
      drive_nxt = drive_r;
      rsp_nxt = 1'b0;
      rdata_nxt = rdata_r;
      wait_nxt = wait_r;
      tif.load = 1'b0;
      tif.count = '0;
      // Spacing counts from the take, whatever the state
      if (wait_r != '0) begin
         wait_nxt = wait_r - 1'b1;
      end
      case (st_r)
         ASC_IDLE: begin
            if (req_ready && req_valid) begin
               addr_nxt = req_addr; // Address set before any strobe [RULE15]
               lanes_nxt = req_lanes;
               wdata_nxt = req_wdata;
               sel_nxt = 1'b1; // Select and enables together [RULE22]
               tif.load = 1'b1;
               if (req_write) begin
                  // Wait for gate release before driving [RULE24]
                  st_nxt = ASC_WR_REL;
                  tif.count = TW'(REL_CYC);
               end else begin
                  gate_nxt = 1'b1;
                  st_nxt = ASC_RD;
                  // Sample after the slowest access path [RULE1] [RULE3] [RULE4] [RULE11]
                  tif.count = TW'(RD_CYC);
               end
            end
         end
         ASC_RD: begin
            if (tif.done) begin
               // Low lane bits 7:0, high lane bits 15:8 [RULE26]
               rdata_nxt = dq_s2_r;
               rsp_nxt = 1'b1;
               gate_nxt = 1'b0;
               sel_nxt = 1'b0; // Memory releases bus after this [RULE23]
               st_nxt = ASC_RD_TURN;
               tif.load = 1'b1;
               tif.count = TW'(TURN_CYC); // Let outputs float [RULE6] [RULE8]
            end
         end
         ASC_RD_TURN: begin
            if (tif.done) begin
               st_nxt = ASC_IDLE;
            end
         end
         ASC_WR_REL: begin
            if (tif.done) begin
               we_nxt = 1'b1;
               drive_nxt = 1'b1; // Data set up for the whole pulse [RULE19]
               st_nxt = ASC_WR;
               tif.load = 1'b1;
               // Pulse covers strobe, select and lane minimums [RULE14] [RULE17] [RULE18]
               tif.count = TW'(PWE_CYC);
            end
         end
         ASC_WR: begin
            if (tif.done) begin
               // Strobe ends the write; selects and data held to this edge [RULE16]
               we_nxt = 1'b0;
               st_nxt = ASC_WR_TAIL;
               tif.load = 1'b1;
               tif.count = TW'(`ASC_TAIL_CYC);
            end
         end
         ASC_WR_TAIL: begin
            if (tif.done) begin
               drive_nxt = 1'b0; // Release before memory may drive [RULE21]
               sel_nxt = 1'b0;
               st_nxt = ASC_IDLE;
            end
         end
         default: begin
            st_nxt = ASC_IDLE;
         end
      endcase
      // Minimum cycle spacing from cycle start [RULE1] [RULE13]
      if (req_ready && req_valid) begin
         wait_nxt = TW'((req_write ? WC_CYC : RC_CYC) - 1);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_r <= ASC_IDLE;
         addr_r <= '0;
         wdata_r <= '0;
         lanes_r <= '0;
         sel_r <= 1'b0;
         gate_r <= 1'b0;
         we_r <= 1'b0;
         drive_r <= 1'b0;
         rsp_r <= 1'b0;
         rdata_r <= '0;
         wait_r <= '0;
      end else begin
         st_r <= st_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         lanes_r <= lanes_nxt;
         sel_r <= sel_nxt;
         gate_r <= gate_nxt;
         we_r <= we_nxt;
         drive_r <= drive_nxt;
         rsp_r <= rsp_nxt;
         rdata_r <= rdata_nxt;
         wait_r <= wait_nxt;
      end
   end

   assign mem_addr = addr_r;
   assign chip_select_n = !sel_r;
   assign chip_select_p = sel_r;
   assign gate_n = !gate_r;
   assign write_strobe_n = !we_r;
   assign lower_lane_enable_n = !(sel_r && lanes_r[`ASC_LO_LANE]); // [RULE26]
   assign upper_lane_enable_n = !(sel_r && lanes_r[`ASC_HI_LANE]); // [RULE26]
   assign mem_dq_o = wdata_r;
   // Drive only enabled lanes while controller owns the bus [RULE24]
   assign mem_dq_oe = {{`ASC_LANE_W{drive_r && lanes_r[`ASC_HI_LANE]}},
      {`ASC_LANE_W{drive_r && lanes_r[`ASC_LO_LANE]}}};
   assign rsp_valid = rsp_r;
   assign rsp_rdata = rdata_r;
endmodule

// file: design/asc_map.svh
// Timing figures, widths and field positions for the static memory controller
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH
`define ASC_CLK_PERIOD_PS 8000
`define ASC_READ_CYCLE_MIN_NS 45
`define ASC_ADDR_ACCESS_MAX_NS 45
`define ASC_GATE_ACCESS_MAX_NS 22
`define ASC_SELECT_RELEASE_MAX_NS 18
`define ASC_GATE_RELEASE_MAX_NS 18
`define ASC_WRITE_CYCLE_MIN_NS 45
`define ASC_STROBE_PULSE_MIN_NS 35
`define ASC_WDATA_SETUP_NS 25
`define ASC_STROBE_RELEASE_MAX_NS 18
`define ASC_LO_LANE 0
`define ASC_HI_LANE 1
`define ASC_LANE_W 8
`define ASC_SYNC_STAGES 2
`define ASC_TAIL_CYC 1
`define ASC_CYC_UP(ns) (((ns) * 1000 + `ASC_CLK_PERIOD_PS - 1) / `ASC_CLK_PERIOD_PS)
`endif

// file: design/asc_pkg.sv
// Types shared by the static memory controller modules
package asc_pkg;
   typedef enum logic [2:0] {
      ASC_IDLE = 3'b000,
      ASC_RD = 3'b001,
      ASC_RD_TURN = 3'b010,
      ASC_WR_REL = 3'b011,
      ASC_WR = 3'b100,
      ASC_WR_TAIL = 3'b101
   } asc_state_t;
   typedef logic [1:0] asc_lanes_t;
endpackage

// file: design/asc_timer.sv
// Down counter timing each phase of a memory cycle
`timescale 1ns/100ps
module asc_timer #(
   parameter int W = 4
) (
   input wire logic mclk, // Clock
   input wire logic rst_n, // Synchronous reset, low
   asc_timer_if.tmr tif // Load and expiry
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   always_comb begin
      if (tif.load) begin
         cnt_nxt = tif.count;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end else begin
         cnt_nxt = cnt_r;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // Expiry seen one cycle early so phase length equals loaded count
   // Independent of load, so ready never loops back through the timer
   assign tif.done = (cnt_r <= W'(1));
endmodule

// file: design/asc_timer_if.sv
// Load and expiry signals between the controller and its cycle timer
`timescale 1ns/100ps
interface asc_timer_if #(parameter int W = 4);
   logic load;
   logic [W-1:0] count;
   logic done;
   modport ctl (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface
